/* File: verilog/dbh_pkg.sv */
// constants and types shared by both ends of the dma out handshake
package dbh_pkg;
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // address lines parked high at the end of a cycle
  localparam logic [ADDR_W-1:0] ADDR_PARK = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // core clock period and the guard window ahead of the grant strobe
  localparam int CORE_PERIOD_NS = 4;
  localparam int GRANT_GAP_NS = 500;
  localparam int GRANT_GAP_CYC =
    (GRANT_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int GAP_W = $clog2(GRANT_GAP_CYC + 1);
  // option bit reset value
  localparam logic ADDRESS_DRIVE_RST = 1'b1;
  // controller end states
  typedef enum logic [1:0] {
    DBH_C_IDLE,
    DBH_C_REQ,
    DBH_C_XFER
  } dbh_ctrl_st_t;
  // glue end states
  typedef enum logic [2:0] {
    DBH_G_IDLE,
    DBH_G_GRANT,
    DBH_G_WRITE,
    DBH_G_HOLD,
    DBH_G_END
  } dbh_glue_st_t;
endpackage : dbh_pkg

/* File: verilog/dbh_if.sv */
// link between the controller end and the bus glue end
interface dbh_if;
  import dbh_pkg::*;
  logic receive_dma_request_n;
  logic dma_grant_strobe_n;
  logic [ADDR_W-1:0] addr;
  logic addr_oe;
  logic [DATA_W-1:0] data;
  logic data_oe;
  modport ctrl (
    output receive_dma_request_n,
    output addr,
    output addr_oe,
    output data,
    output data_oe,
    input dma_grant_strobe_n
  );
  modport glue (
    input receive_dma_request_n,
    input addr,
    input addr_oe,
    input data,
    input data_oe,
    output dma_grant_strobe_n
  );
endinterface : dbh_if

/* File: verilog/dbh_ctrl.sv */
// controller end: requests the bus and writes one byte per cycle
module dbh_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // link to the bus glue
  dbh_if.ctrl LNK,
  // byte source
  input wire logic BYTE_VALID,
  input wire logic [dbh_pkg::DATA_W-1:0] BYTE_DATA,
  input wire logic [dbh_pkg::ADDR_W-1:0] BYTE_ADDR,
  input wire logic ADDRESS_DRIVE_OPTION,
  // status
  output logic BYTE_TAKEN,
  output logic BYTE_DONE,
  output logic BUSY
);
  import dbh_pkg::*;

  typedef struct packed {
    dbh_ctrl_st_t st;
    logic req_n;
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic drive;
    logic taken;
    logic done;
  } dbh_ctrl_s_t;

  dbh_ctrl_s_t s_r;
  dbh_ctrl_s_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.taken = 1'b0;
    s_nxt.done = 1'b0;
    case (s_r.st)
      DBH_C_IDLE: begin
        if (BYTE_VALID) begin
          s_nxt.st = DBH_C_REQ;
          s_nxt.req_n = 1'b0;
          s_nxt.data = BYTE_DATA;
          s_nxt.drive = ADDRESS_DRIVE_OPTION;
          s_nxt.addr = BYTE_ADDR;
          s_nxt.addr_oe = ADDRESS_DRIVE_OPTION;
          s_nxt.taken = 1'b1;
        end
      end
      DBH_C_REQ: begin
        if (!LNK.dma_grant_strobe_n) begin
          s_nxt.st = DBH_C_XFER;
          s_nxt.req_n = 1'b1;
          s_nxt.data_oe = 1'b1;
        end
      end
      DBH_C_XFER: begin
        if (LNK.dma_grant_strobe_n) begin
          s_nxt.st = DBH_C_IDLE;
          s_nxt.data_oe = 1'b0;
          s_nxt.addr = ADDR_PARK;
          s_nxt.addr_oe = s_r.drive;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = DBH_C_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r.st <= DBH_C_IDLE;
      s_r.req_n <= 1'b1;
      s_r.addr <= ADDR_PARK;
      s_r.addr_oe <= 1'b0;
      s_r.data <= DATA_RST;
      s_r.data_oe <= 1'b0;
      s_r.drive <= ADDRESS_DRIVE_RST;
      s_r.taken <= 1'b0;
      s_r.done <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign LNK.receive_dma_request_n = s_r.req_n;
  assign LNK.addr = s_r.addr;
  assign LNK.addr_oe = s_r.addr_oe;
  assign LNK.data = s_r.data;
  assign LNK.data_oe = s_r.data_oe;
  assign BYTE_TAKEN = s_r.taken;
  assign BYTE_DONE = s_r.done;
  assign BUSY = (s_r.st != DBH_C_IDLE);
endmodule : dbh_ctrl

/* File: verilog/dbh_glue.sv */
// bus glue end: bus request stretching, grant and memory strobes
// Notes on behaviour
// - controller requests bus when byte ready
// - address driven with request when option set
// - cpu samples request, then grants bus
// - grant strobe low on the interface edge after delayed grant and guard window
// - controller drops request, drives data on grant
// - write strobe low one interface edge later
// - write strobe high on following edge
// - bus request released per cpu clock option
// - grant rises one core edge after write strobe
// - cpu drops grant after request released
// - transceiver toward cpu on register reads, dma out
// - address latch enabled during dma cycles
// - dma read strobe only in dma in
// - memory output strobe on memory reads
// - memory write strobe on dma, cpu writes
// - decode enable on any memory access
// - loop test: rts held off, looped
// - delayed grant one interface cycle later
// - first request drives stretched and slow request
// - stretched request releases one cycle later
// - fast clock: extra stretch drives request
// - interface clock is cpu clock or half
module dbh_glue (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // link to the controller
  dbh_if.glue LNK,
  // options
  input wire logic FAST_CPU_CLOCK,
  input wire logic INTERNAL_LOOP_SELECT,
  // cpu bus handshake
  input wire logic CPU_BUS_GRANT_N,
  output logic CPU_BUS_REQUEST_N,
  // cpu accesses
  input wire logic CPU_MEM_READ,
  input wire logic CPU_MEM_WRITE,
  input wire logic CPU_REG_READ,
  // memory side
  output logic [dbh_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [dbh_pkg::DATA_W-1:0] MEM_DATA,
  output logic MEMORY_WRITE_STROBE_N,
  output logic MEMORY_OUTPUT_STROBE_N,
  output logic DMA_READ_OUTPUT_STROBE_N,
  output logic MEMORY_DECODE_ENABLE_N,
  output logic TRANSCEIVER_TOWARD_CPU_N,
  output logic ADDRESS_LATCH_OUTPUT_ENABLE_N,
  output logic HALVED_CPU_CLOCK,
  // modem lines
  input wire logic RTS_FROM_CTRL_N,
  input wire logic MODEM_CTS_N,
  output logic MODEM_RTS_N,
  output logic CTS_TO_CTRL_N
);
  import dbh_pkg::*;

  typedef struct packed {
    dbh_glue_st_t st;
    logic half;
    logic first_req;
    logic stretched_req;
    logic extra_req;
    logic grant_seen;
    logic delayed_grant;
    logic [GAP_W-1:0] gap;
    logic grant_n;
    logic bus_req_n;
    logic mwe_n;
    logic moe_n;
    logic dma_read_output_strobe_n;
    logic mrw_n;
    logic rcv_n;
    logic address_latch_output_enable_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic rts_n;
    logic cts_n;
  } dbh_glue_s_t;

  dbh_glue_s_t s_r;
  dbh_glue_s_t s_nxt;
  logic tick;
  logic dma_cyc;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    // interface clock edge: every core edge, or every second one
    s_nxt.half = ~s_r.half;
    tick = FAST_CPU_CLOCK ? s_r.half : 1'b1;
    // request stretch chain, one interface cycle per stage
    if (tick) begin
      s_nxt.first_req = ~LNK.receive_dma_request_n;
      s_nxt.stretched_req = s_nxt.first_req | s_r.first_req;
      s_nxt.extra_req = s_nxt.stretched_req | s_r.stretched_req;
      s_nxt.grant_seen = ~CPU_BUS_GRANT_N;
      s_nxt.delayed_grant = ~CPU_BUS_GRANT_N & s_r.grant_seen;
    end
    if (CPU_BUS_GRANT_N) begin
      s_nxt.delayed_grant = 1'b0;
    end
    // slow clock: first request also drives the cpu directly
    if (FAST_CPU_CLOCK) begin
      s_nxt.bus_req_n = ~s_nxt.extra_req;
    end else begin
      s_nxt.bus_req_n = ~(s_nxt.stretched_req | s_nxt.first_req);
    end
    // guard window count while the delayed grant stands
    if (!s_r.delayed_grant) begin
      s_nxt.gap = '0;
    end else if (s_r.gap != GAP_W'(GRANT_GAP_CYC)) begin
      s_nxt.gap = s_r.gap + GAP_W'(1);
    end
    // dma out sequence
    case (s_r.st)
      DBH_G_IDLE: begin
        if (tick && s_r.delayed_grant && s_r.first_req &&
            s_r.gap == GAP_W'(GRANT_GAP_CYC)) begin
          s_nxt.st = DBH_G_GRANT;
          s_nxt.grant_n = 1'b0;
        end
      end
      DBH_G_GRANT: begin
        if (tick) begin
          s_nxt.st = DBH_G_WRITE;
          s_nxt.mwe_n = 1'b0;
        end
      end
      DBH_G_WRITE: begin
        if (tick) begin
          s_nxt.st = DBH_G_HOLD;
        end
      end
      DBH_G_HOLD: begin
        // grant rises one core edge after the write strobe
        s_nxt.st = DBH_G_END;
        s_nxt.grant_n = 1'b1;
      end
      DBH_G_END: begin
        if (CPU_BUS_GRANT_N) begin
          s_nxt.st = DBH_G_IDLE;
        end
      end
      default: begin
        s_nxt.st = DBH_G_IDLE;
      end
    endcase
    dma_cyc = (s_nxt.st != DBH_G_IDLE) && (s_nxt.st != DBH_G_END);
    // memory and transceiver strobes
    s_nxt.mwe_n = ~((s_nxt.st == DBH_G_WRITE) | CPU_MEM_WRITE);
    s_nxt.moe_n = ~CPU_MEM_READ;
    s_nxt.dma_read_output_strobe_n = 1'b1;
    s_nxt.mrw_n = ~(dma_cyc | CPU_MEM_READ | CPU_MEM_WRITE);
    s_nxt.rcv_n = ~(dma_cyc | CPU_REG_READ);
    s_nxt.address_latch_output_enable_n = ~dma_cyc;
    // latched controller address and data toward memory
    if (LNK.addr_oe) begin
      s_nxt.addr = LNK.addr;
    end
    // byte already stands on the controller register when grant falls;
    // taking it then keeps data valid for the whole write strobe
    if (LNK.data_oe || s_r.st == DBH_G_GRANT) begin
      s_nxt.data = LNK.data;
    end
    // loop test routing
    s_nxt.rts_n = INTERNAL_LOOP_SELECT | RTS_FROM_CTRL_N;
    s_nxt.cts_n = INTERNAL_LOOP_SELECT ? RTS_FROM_CTRL_N
                                       : MODEM_CTS_N;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, all strobes inactive at reset
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r.st <= DBH_G_IDLE;
      s_r.half <= 1'b0;
      s_r.first_req <= 1'b0;
      s_r.stretched_req <= 1'b0;
      s_r.extra_req <= 1'b0;
      s_r.grant_seen <= 1'b0;
      s_r.delayed_grant <= 1'b0;
      s_r.gap <= '0;
      s_r.grant_n <= 1'b1;
      s_r.bus_req_n <= 1'b1;
      s_r.mwe_n <= 1'b1;
      s_r.moe_n <= 1'b1;
      s_r.dma_read_output_strobe_n <= 1'b1;
      s_r.mrw_n <= 1'b1;
      s_r.rcv_n <= 1'b1;
      s_r.address_latch_output_enable_n <= 1'b1;
      s_r.addr <= ADDR_PARK;
      s_r.data <= DATA_RST;
      s_r.rts_n <= 1'b1;
      s_r.cts_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign LNK.dma_grant_strobe_n = s_r.grant_n;
  assign CPU_BUS_REQUEST_N = s_r.bus_req_n;
  assign MEM_ADDR = s_r.addr;
  assign MEM_DATA = s_r.data;
  assign MEMORY_WRITE_STROBE_N = s_r.mwe_n;
  assign MEMORY_OUTPUT_STROBE_N = s_r.moe_n;
  assign DMA_READ_OUTPUT_STROBE_N = s_r.dma_read_output_strobe_n;
  assign MEMORY_DECODE_ENABLE_N = s_r.mrw_n;
  assign TRANSCEIVER_TOWARD_CPU_N = s_r.rcv_n;
  assign ADDRESS_LATCH_OUTPUT_ENABLE_N = s_r.address_latch_output_enable_n;
  assign HALVED_CPU_CLOCK = s_r.half;
  assign MODEM_RTS_N = s_r.rts_n;
  assign CTS_TO_CTRL_N = s_r.cts_n;
endmodule : dbh_glue

/* File: testbench/dbh_link_sva.sv */
// link checker for the dma out handshake pair
module dbh_link_sva (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // link signals
  input wire logic receive_dma_request_n,
  input wire logic dma_grant_strobe_n,
  input wire logic [dbh_pkg::ADDR_W-1:0] addr,
  input wire logic addr_oe,
  input wire logic [dbh_pkg::DATA_W-1:0] data,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbh_pkg::*;
  logic [7:0] gap_r;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the request went low, saturating
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) gap_r <= 8'h00;
    else if (receive_dma_request_n) gap_r <= 8'h00;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  // steps of one bus cycle
  sequence s_grant_on;
    $fell(dma_grant_strobe_n);
  endsequence
  sequence s_grant_off;
    $rose(dma_grant_strobe_n);
  endsequence
  a_reset_idle: assert property ($rose(RSTN) |-> receive_dma_request_n &&
    dma_grant_strobe_n && !data_oe && addr == ADDR_PARK)
    else $error("link not idle after reset");
  a_req_held: assert property ((!receive_dma_request_n &&
    dma_grant_strobe_n) |=> !receive_dma_request_n)
    else $error("request dropped before grant");
  a_addr_with_req: assert property ($fell(receive_dma_request_n) |->
    addr_oe && addr != ADDR_PARK)
    else $error("address missing with request");
  a_grant_on_req: assert property (s_grant_on |->
    !receive_dma_request_n)
    else $error("grant without request");
  a_req_drop_data: assert property (s_grant_on |=>
    receive_dma_request_n && data_oe)
    else $error("request or data wrong after grant");
  a_grant_gap: assert property (s_grant_on |->
    gap_r >= GRANT_GAP_CYC)
    else $error("grant guard window too short");
  a_grant_short: assert property (s_grant_on |=>
    !dma_grant_strobe_n ##[1:6] dma_grant_strobe_n)
    else $error("grant length wrong");
  a_cycle_end: assert property (s_grant_off |=>
    !data_oe && addr == ADDR_PARK)
    else $error("cycle end not parked");
  a_data_stable: assert property (data_oe && $past(data_oe) |->
    $stable(data))
    else $error("data moved while driven");
endmodule : dbh_link_sva

/* File: testbench/dma_out_bus_handshake_glue_bench.sv */
// self-checking bench for the dma out handshake pair
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module dma_out_bus_handshake_glue_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dbh_pkg::*;
  logic clk = 0, rstn = 0, valid = 0, opt = 1, fast = 0, loop = 0;
  logic grant_n = 1, mrd = 0, mwr = 0, rrd = 0, rts_n = 1, cts_n = 1;
  logic [7:0] bdata = 8'h00, mdata;
  logic [15:0] baddr = 16'h0000, maddr;
  logic taken, done, busy, breq_n, mwe_n, moe_n, dma_read_output_strobe_n, mrw_n, rcv_n;
  logic address_latch_output_enable_n, half, mrts_n, ccts_n;
  int n_fail = 0, samples_checked = 0;
  dbh_if lnk();
  dbh_ctrl u_dbh_ctrl(.CORE_CLK(clk), .RSTN(rstn), .LNK(lnk),
    .BYTE_VALID(valid), .BYTE_DATA(bdata), .BYTE_ADDR(baddr),
    .ADDRESS_DRIVE_OPTION(opt), .BYTE_TAKEN(taken), .BYTE_DONE(done),
    .BUSY(busy));
  dbh_glue u_dbh_glue(.CORE_CLK(clk), .RSTN(rstn), .LNK(lnk),
    .FAST_CPU_CLOCK(fast), .INTERNAL_LOOP_SELECT(loop),
    .CPU_BUS_GRANT_N(grant_n), .CPU_BUS_REQUEST_N(breq_n),
    .CPU_MEM_READ(mrd), .CPU_MEM_WRITE(mwr), .CPU_REG_READ(rrd),
    .MEM_ADDR(maddr), .MEM_DATA(mdata), .MEMORY_WRITE_STROBE_N(mwe_n),
    .MEMORY_OUTPUT_STROBE_N(moe_n), .DMA_READ_OUTPUT_STROBE_N(dma_read_output_strobe_n),
    .MEMORY_DECODE_ENABLE_N(mrw_n), .TRANSCEIVER_TOWARD_CPU_N(rcv_n),
    .ADDRESS_LATCH_OUTPUT_ENABLE_N(address_latch_output_enable_n), .HALVED_CPU_CLOCK(half),
    .RTS_FROM_CTRL_N(rts_n), .MODEM_CTS_N(cts_n), .MODEM_RTS_N(mrts_n),
    .CTS_TO_CTRL_N(ccts_n));
  dbh_link_sva u_dbh_link_sva(.CORE_CLK(clk), .RSTN(rstn),
    .receive_dma_request_n(lnk.receive_dma_request_n),
    .dma_grant_strobe_n(lnk.dma_grant_strobe_n), .addr(lnk.addr),
    .addr_oe(lnk.addr_oe), .data(lnk.data), .data_oe(lnk.data_oe));
  ////////////////////////////////////////////////////////////////////////////
  // clock and cpu: grant follows request one edge later
  always #2 clk = ~clk;
  always @(posedge clk) grant_n <= breq_n;
  ////////////////////////////////////////////////////////////////////////////
  // expected write strobe length in core cycles
  function automatic int mwe_cycles(logic f);
    return f ? 2 : 1;
  endfunction : mwe_cycles
  task finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // bounded wait for a level
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; n < 3000; n++) begin
      if (s === v) return;
      @(posedge clk);
      #1;
    end
    n_fail++;
    finish_test();
  endtask : wait_for
  // one cpu access with random modem lines
  task automatic cpu_access(int k);
    logic h;
    @(posedge clk);
    mrd <= (k == 1);
    mwr <= (k == 2);
    rrd <= (k == 3);
    loop <= 1'($urandom);
    rts_n <= 1'($urandom);
    cts_n <= 1'($urandom);
    #1 h = half;
    @(posedge clk);
    #1;
    `CHK(half, ~h)
    `CHK(moe_n, k != 1)
    `CHK(mwe_n, k != 2)
    `CHK(mrw_n, !(k == 1 || k == 2))
    `CHK(rcv_n, k != 3)
    `CHK(address_latch_output_enable_n, 1'b1)
    `CHK(mrts_n, loop | rts_n)
    `CHK(ccts_n, loop ? rts_n : cts_n)
  endtask : cpu_access
  // one byte written to memory through the pair
  task automatic byte_cycle(int i);
    logic [7:0] d;
    logic [15:0] a;
    int w;
    d = (i == 0) ? 8'hFF : 8'($urandom);
    a = (i == 0) ? 16'h0000 : 16'($urandom_range(65534));
    @(posedge clk);
    valid <= 1;
    bdata <= d;
    baddr <= a;
    wait_for(taken, 1'b1);
    @(posedge clk) valid <= 0;
    wait_for(mwe_n, 1'b0);
    `CHK(maddr, a)
    `CHK(mdata, d)
    `CHK(breq_n, 1'b0)
    `CHK(busy, 1'b1)
    `CHK({mrw_n, rcv_n, address_latch_output_enable_n, dma_read_output_strobe_n, moe_n}, 5'h03)
    w = 0;
    while (mwe_n === 1'b0 && w < 9) begin
      @(posedge clk);
      #1 w++;
    end
    `CHK(w, mwe_cycles(fast))
    wait_for(done, 1'b1);
    `CHK(busy, 1'b0)
    wait_for(breq_n, 1'b1);
  endtask : byte_cycle
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(82132));
    repeat (4) @(posedge clk);
    #1;
    `CHK({breq_n, mwe_n, moe_n, dma_read_output_strobe_n, mrw_n, rcv_n, address_latch_output_enable_n}, 7'h7F)
    `CHK(busy, 1'b0)
    @(posedge clk) rstn <= 1;
    for (int k = 0; k < 12; k++) cpu_access(k < 4 ? k : $urandom_range(3));
    @(posedge clk);
    {mrd, mwr, rrd} <= 3'h0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) fast <= (i >= 6);
      byte_cycle(i);
    end
    finish_test();
  end
endmodule : dma_out_bus_handshake_glue_bench
